// *** serial_decimal_count_tally.sv ***
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ns
// What this block does
// - Add command: adder output is the held digit plus one.
// - Subtract command: adder output is the held digit minus one.
// - Neither command: adder passes the held digit unchanged.
// - Store request starts four phase pulses in order, each on its own line.
// - Phases follow back to back; three last 4 us, the last 1 us.
// - Phase one clears, two reads and strobes, three writes, four resets scalers.
// - Read clears the digit location; write puts the adder output there.
// - Group overflow pulse when advances reach 128, 256 or 512 by group.
// - Overflow still runs the cycle but a non-add flag blocks the count.
// - Upper address bits forced to the selected quadrant or half.
// - Holding register preset to 0010 after the last cycle until next analysis.
// - Non-add flag returns to normal after a non-add cycle completes.
// - Carry on nine when adding or zero when subtracting repeats on next digit.
// - Store request without advances and with clock trigger counts into channel zero.
// - Shortest timing halts on any access to digit five of channel zero.
// - Two-minute timing also needs a one read from digit five.
// - Ten minutes halts on digit six; twenty also needs a one read.
// - Other timings use the same digit access and value scheme.
// - When subtracting, halt only on access to digit six of channel zero.
// - Each memory cycle works on one digit; next digit only on carry.
// - Digits are four-bit BCD, codes 0000 to 1001 only.
// - Channel zero counts are blocked unless the clock trigger is active.
module serial_decimal_count_tally
    import tally_pkg::*;
#(
    parameter int MEM_AW = 12
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        adv_pulse,
    input  wire logic        convert_done_store,
    input  wire logic        store_reject,
    input  wire logic        clock_trigger,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    output logic             phase_one_clear,
    output logic             phase_two_read,
    output logic             phase_three_write,
    output logic             phase_four_finish,
    output logic             group_overflow,
    output logic             auto_halt,
    output logic             busy
);

    typedef struct packed {
        phase_e           st;
        logic [TMR_W-1:0] tmr;
        logic [9:0]       cnt;
        logic [2:0]       digit;
        logic [3:0]       m;
        logic             non_add;
        logic             ovf_seen;
        logic             ovf;
        logic             halt;
        logic             busy;
        logic [3:0]       ph;
        logic [7:0]       ctrl;
        logic [MEM_AW-1:0] maddr;
        logic             bus_wait;
        logic [31:0]      rdata;
        logic [3:0]       s1;
        logic [3:0]       s2;
        logic [3:0]       s3;
        logic [3:0]       filt;
        logic [3:0]       filt_d;
    } state_s;

    state_s s;
    state_s next_s;

    logic [3:0]        core [0:(1<<MEM_AW)-1];
    logic [MEM_AW-1:0] eaddr;
    logic [3:0]        rd;
    logic [3:0]        add_out;
    logic              carry;
    logic              sub;
    logic              p2_first;
    logic              p3_first;
    logic              req;
    logic              bus_take;

    // Assertions below share this clock and reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Channel number with upper bits forced to the selected section
    function automatic logic [8:0] force_chan(input logic [8:0] c, input logic [1:0] grp,
                                              input logic [1:0] sec);
        case (grp)
            2'b00:   force_chan = c;
            2'b01:   force_chan = {sec[0], c[7:0]};
            default: force_chan = {sec, c[6:0]};
        endcase
    endfunction

    // Advance count that signals group overflow
    function automatic logic [9:0] group_size(input logic [1:0] grp);
        case (grp)
            2'b00:   group_size = FULL_SIZE;
            2'b01:   group_size = HALF_SIZE;
            default: group_size = QUAD_SIZE;
        endcase
    endfunction

    // Auto-halt match for a channel-zero access to a digit with a read value
    function automatic logic halt_hit(input logic [2:0] tsel, input logic subt,
                                      input logic [2:0] dig, input logic [3:0] val);
        if (subt) begin
            halt_hit = (dig == DIG_SIXTH);
        end else begin
            case (time_sel_e'(tsel))
                T_1M:    halt_hit = (dig == DIG_FIFTH);
                T_2M:    halt_hit = (dig == DIG_FIFTH) && (val == 4'h1);
                T_4M:    halt_hit = (dig == DIG_FIFTH) && (val == 4'h3);
                T_8M:    halt_hit = (dig == DIG_FIFTH) && (val == 4'h7);
                T_10M:   halt_hit = (dig == DIG_SIXTH);
                T_20M:   halt_hit = (dig == DIG_SIXTH) && (val == 4'h1);
                T_40M:   halt_hit = (dig == DIG_SIXTH) && (val == 4'h3);
                default: halt_hit = (dig == DIG_SIXTH) && (val == 4'h7);
            endcase
        end
    endfunction

    // Memory address, adder and carry recognition
    always_comb begin
        sub      = s.ctrl[CTRL_SUB];
        eaddr    = {force_chan(s.cnt[8:0], s.ctrl[CTRL_GRP+:2], s.ctrl[CTRL_SEC+:2]),
                    s.digit};
        rd       = core[eaddr];
        p2_first = (s.st == ST_P2) && (s.tmr == TMR_W'(PHASE_CYC - 1));
        p3_first = (s.st == ST_P3) && (s.tmr == TMR_W'(PHASE_CYC - 1));
        req      = read || write;
        bus_take = req && !s.bus_wait;
        if (s.non_add) begin
            add_out = s.m;
        end else if (sub) begin
            add_out = (s.m == M_CLEAR) ? M_NINE : s.m - 4'h1;
        end else begin
            add_out = (s.m == M_NINE) ? M_CLEAR : s.m + 4'h1;
        end
        carry = !s.non_add && (sub ? (s.m == M_CLEAR) : (s.m == M_NINE));
    end

    // Digit memory: destructive read at strobe, write-back, software access
    always_ff @(posedge clk) begin
        if (p2_first) begin
            core[eaddr] <= M_CLEAR;
        end else if (p3_first) begin
            core[eaddr] <= add_out;
        end else if (bus_take && write && address == OFS_MDATA && byteenable[0]) begin
            core[s.maddr] <= writedata[3:0];
        end
    end

    // Next-state logic: pins, bus slave and phase sequencer
    always_comb begin
        logic adv_rise;
        logic store_rise;
        logic [9:0] cnt_inc;
        next_s       = s;
        adv_rise     = 1'b0;
        store_rise   = 1'b0;
        cnt_inc      = s.cnt + 10'h001;
        next_s.ovf   = 1'b0;
        // Three-stage pin sampling; a level counts once stages two and three agree
        next_s.s1     = {clock_trigger, store_reject, convert_done_store, adv_pulse};
        next_s.s2     = s.s1;
        next_s.s3     = s.s2;
        next_s.filt   = (s.s2 & s.s3) | (s.filt & (s.s2 ^ s.s3));
        next_s.filt_d = s.filt;
        adv_rise      = s.filt[PIN_ADV] && !s.filt_d[PIN_ADV];
        store_rise    = s.filt[PIN_STORE] && !s.filt_d[PIN_STORE];

        // Bus slave: one wait cycle, then answer for one cycle
        if (req && s.bus_wait) begin
            next_s.bus_wait = 1'b0;
            case (address)
                OFS_CTRL:  next_s.rdata = {24'h000000, s.ctrl};
                OFS_STAT:  next_s.rdata = {12'h000, s.cnt, s.digit, s.m, s.non_add,
                                           s.halt, s.busy};
                OFS_MADDR: next_s.rdata = {{(32-MEM_AW){1'b0}}, s.maddr};
                OFS_MDATA: next_s.rdata = {28'h0000000, core[s.maddr]};
                default:   next_s.rdata = 32'h00000000;
            endcase
        end else begin
            next_s.bus_wait = 1'b1;
        end
        if (bus_take && write) begin
            if (address == OFS_CTRL && byteenable[0]) begin
                next_s.ctrl = writedata[7:0];
            end
            if (address == OFS_STAT && byteenable[0] && writedata[STAT_HALT]) begin
                next_s.halt = 1'b0;
            end
            if (address == OFS_MADDR) begin
                if (byteenable[0]) begin
                    next_s.maddr[7:0] = writedata[7:0];
                end
                if (byteenable[1]) begin
                    next_s.maddr[MEM_AW-1:8] = writedata[MEM_AW-1:8];
                end
            end
        end

        // Phase sequencer
        case (s.st)
            ST_IDLE: begin
                if (store_rise) begin
                    next_s.st      = ST_P1;
                    next_s.tmr     = TMR_W'(PHASE_CYC - 1);
                    next_s.non_add = s.non_add | s.filt[PIN_REJ] | s.ovf_seen
                                   | ((s.cnt == 10'h000) & !s.filt[PIN_CLK]);
                end else if (adv_rise && s.cnt != FULL_SIZE) begin
                    next_s.cnt = cnt_inc;
                    if (cnt_inc == group_size(s.ctrl[CTRL_GRP+:2]) && !s.ovf_seen) begin
                        next_s.ovf      = 1'b1;
                        next_s.ovf_seen = 1'b1;
                    end
                end
            end
            ST_P1: begin
                next_s.m   = M_CLEAR;
                next_s.tmr = s.tmr - TMR_W'(1);
                if (s.tmr == '0) begin
                    next_s.st  = ST_P2;
                    next_s.tmr = TMR_W'(PHASE_CYC - 1);
                end
            end
            ST_P2: begin
                next_s.tmr = s.tmr - TMR_W'(1);
                if (p2_first) begin
                    next_s.m = rd;
                    if (s.cnt == 10'h000 && halt_hit(s.ctrl[CTRL_TIME+:3], sub, s.digit, rd)) begin
                        next_s.halt = 1'b1;
                    end
                end
                if (s.tmr == '0) begin
                    next_s.st  = ST_P3;
                    next_s.tmr = TMR_W'(PHASE_CYC - 1);
                end
            end
            ST_P3: begin
                next_s.tmr = s.tmr - TMR_W'(1);
                if (s.tmr == '0) begin
                    next_s.st  = ST_P4;
                    next_s.tmr = TMR_W'(LAST_CYC - 1);
                end
            end
            ST_P4: begin
                next_s.tmr = s.tmr - TMR_W'(1);
                if (s.tmr == '0) begin
                    if (carry && s.digit != DIG_SIXTH) begin
                        next_s.st    = ST_P1;
                        next_s.digit = s.digit + 3'h1;
                        next_s.tmr   = TMR_W'(PHASE_CYC - 1);
                    end else begin
                        next_s.st       = ST_IDLE;
                        next_s.cnt      = 10'h000;
                        next_s.digit    = 3'h0;
                        next_s.m        = M_PRESET;
                        next_s.non_add  = 1'b0;
                        next_s.ovf_seen = 1'b0;
                    end
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
        next_s.ph   = {next_s.st == ST_P4, next_s.st == ST_P3,
                       next_s.st == ST_P2, next_s.st == ST_P1};
        next_s.busy = (next_s.st != ST_IDLE);
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s          <= '0;
            s.st       <= ST_IDLE;
            s.ctrl     <= CTRL_RST;
            s.m        <= M_PRESET;
            s.bus_wait <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign readdata          = s.rdata;
    assign waitrequest       = s.bus_wait;
    assign phase_one_clear   = s.ph[0];
    assign phase_two_read    = s.ph[1];
    assign phase_three_write = s.ph[2];
    assign phase_four_finish = s.ph[3];
    assign group_overflow    = s.ovf;
    assign auto_halt         = s.halt;
    assign busy              = s.busy;

    // Helper: length of the current phase pulse
    logic [TMR_W:0] run;
    always_ff @(posedge clk) begin
        if (!rst_b || s.ph != next_s.ph) begin
            run <= '0;
        end else begin
            run <= run + (TMR_W+1)'(1);
        end
    end

    property p_add;
        p3_first && !s.non_add && !sub && s.m != M_NINE |=> core[$past(eaddr)] == $past(s.m) + 4'h1;
    endproperty
    a_add: assert property (p_add) else $error("add result wrong");

    property p_sub;
        p3_first && !s.non_add && sub && s.m != M_CLEAR |=> core[$past(eaddr)] == $past(s.m) - 4'h1;
    endproperty
    a_sub: assert property (p_sub) else $error("subtract result wrong");

    property p_idle;
        p3_first && s.non_add |=> core[$past(eaddr)] == $past(s.m);
    endproperty
    a_idle: assert property (p_idle) else $error("idle adder altered digit");

    property p_order;
        ($rose(phase_two_read) |-> $past(phase_one_clear)) and
        ($rose(phase_three_write) |-> $past(phase_two_read)) and
        ($rose(phase_four_finish) |-> $past(phase_three_write));
    endproperty
    a_order: assert property (p_order) else $error("phase order broken");

    property p_len;
        ($fell(phase_one_clear) || $fell(phase_three_write)) |-> $past(run) == PHASE_CYC - 1;
    endproperty
    a_len: assert property (p_len) else $error("phase length wrong");

    property p_last;
        $fell(phase_four_finish) |-> $past(run) == LAST_CYC - 1;
    endproperty
    a_last: assert property (p_last) else $error("last phase length wrong");

    property p_destroy;
        p2_first |=> core[$past(eaddr)] == M_CLEAR && s.m == $past(rd);
    endproperty
    a_destroy: assert property (p_destroy) else $error("read not destructive");

    property p_ovf;
        group_overflow |-> s.cnt == group_size(s.ctrl[CTRL_GRP+:2]) && s.ovf_seen;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow at wrong count");

    property p_nadd;
        $rose(busy) && $past(s.ovf_seen) |-> s.non_add;
    endproperty
    a_nadd: assert property (p_nadd) else $error("overflow cycle not non-add");

    property p_preset;
        $fell(busy) |-> s.m == M_PRESET && !s.non_add;
    endproperty
    a_preset: assert property (p_preset) else $error("no preset after cycle");

    property p_repeat;
        s.st == ST_P4 && s.tmr == '0 && carry && s.digit != DIG_SIXTH
            |=> phase_one_clear && s.digit == $past(s.digit) + 3'h1;
    endproperty
    a_repeat: assert property (p_repeat) else $error("carry did not repeat");

    property p_halt;
        $rose(auto_halt) |-> $past(s.cnt) == 10'h000 && $past(p2_first);
    endproperty
    a_halt: assert property (p_halt) else $error("halt without channel zero access");

    c_carry: cover property (s.st == ST_P4 && s.tmr == '0 && carry ##1 phase_one_clear);
    c_ovf:   cover property (group_overflow ##[1:1000] $rose(busy));
    c_halt:  cover property ($rose(auto_halt));
    c_bus:   cover property (read && !waitrequest);

endmodule // serial_decimal_count_tally

// *** tally_pkg.sv ***
package tally_pkg;

    // Clock and phase timing
    localparam int CLK_MHZ   = 250;
    localparam int PHASE_US  = 4;                   // First three phases
    localparam int LAST_US   = 1;                   // Final phase
    localparam int PHASE_CYC = PHASE_US * CLK_MHZ;  // 1000 cycles
    localparam int LAST_CYC  = LAST_US * CLK_MHZ;   // 250 cycles
    localparam int TMR_W     = 10;

    // Register byte offsets
    localparam logic [3:0] OFS_CTRL  = 4'h0;
    localparam logic [3:0] OFS_STAT  = 4'h4;
    localparam logic [3:0] OFS_MADDR = 4'h8;
    localparam logic [3:0] OFS_MDATA = 4'hC;

    // Control field positions and reset value
    localparam int CTRL_SUB  = 0;  // 1 = subtract
    localparam int CTRL_GRP  = 1;  // 2 bits: 0 full, 1 half, 2/3 quadrant
    localparam int CTRL_SEC  = 3;  // 2 bits: section of memory in use
    localparam int CTRL_TIME = 5;  // 3 bits: auto-halt timing selection
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Status field positions
    localparam int STAT_BUSY  = 0;  // Write 1 here does nothing
    localparam int STAT_HALT  = 1;  // Write 1 clears auto-halt
    localparam int STAT_NADD  = 2;
    localparam int STAT_M     = 3;
    localparam int STAT_DIGIT = 7;
    localparam int STAT_CNT   = 10;

    // Holding register values and digit positions
    localparam logic [3:0] M_CLEAR   = 4'h0;
    localparam logic [3:0] M_PRESET  = 4'h2;
    localparam logic [3:0] M_NINE    = 4'h9;
    localparam logic [2:0] DIG_FIFTH = 3'h4;
    localparam logic [2:0] DIG_SIXTH = 3'h5;

    // Group sizes in advance pulses
    localparam logic [9:0] QUAD_SIZE = 10'h080;
    localparam logic [9:0] HALF_SIZE = 10'h100;
    localparam logic [9:0] FULL_SIZE = 10'h200;

    // Synchronised pin indices
    localparam int PIN_ADV   = 0;
    localparam int PIN_STORE = 1;
    localparam int PIN_REJ   = 2;
    localparam int PIN_CLK   = 3;

    typedef enum logic [2:0] {
        T_1M, T_2M, T_4M, T_8M, T_10M, T_20M, T_40M, T_80M
    } time_sel_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_P1   = 3'b001,
        ST_P2   = 3'b011,
        ST_P3   = 3'b010,
        ST_P4   = 3'b110
    } phase_e;

endpackage

// *** converter_model.sv ***
`timescale 1ns/1ns
// Converter front end: address advances, then a store request with its qualifiers
module converter_model (
    input  wire logic clk,
    output logic      adv_pulse,
    output logic      convert_done_store,
    output logic      store_reject,
    output logic      clock_trigger
);
    // Idle levels from time zero
    initial begin
        adv_pulse = 1'b0;
        convert_done_store = 1'b0;
        store_reject = 1'b0;
        clock_trigger = 1'b0;
    end

    // Channel set by advances first, store raised only afterwards
    task automatic run(input int n, input logic rej, input logic trig);
        int i;
        store_reject <= rej;
        clock_trigger <= trig;
        for (i = 0; i < n; i++) begin
            repeat (6) @(posedge clk);
            adv_pulse <= 1'b1;
            repeat (6) @(posedge clk);
            adv_pulse <= 1'b0;
        end
        repeat (6) @(posedge clk);
        convert_done_store <= 1'b1;
        repeat (8) @(posedge clk);
        convert_done_store <= 1'b0;
        store_reject <= 1'b0;
        clock_trigger <= 1'b0;
    endtask
endmodule // converter_model

// *** test_serial_decimal_count_tally.sv ***
`timescale 1ns/1ns
`define CHK(what, exp, got) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
        end \
    end

module test_serial_decimal_count_tally import tally_pkg::*;;
    logic        clk;
    logic        rst_b;
    logic        adv_pulse;
    logic        convert_done_store;
    logic        store_reject;
    logic        clock_trigger;
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        phase_one_clear;
    logic        phase_two_read;
    logic        phase_three_write;
    logic        phase_four_finish;
    logic        group_overflow;
    logic        auto_halt;
    logic        busy;
    logic [3:0]  ph;
    logic [31:0] rd;
    int          mismatches = 0;
    int          checks_done = 0;
    int          ovf_seen = 0;
    int          t;
    int          j;
    logic [2:0]  halt_sel [3] = '{3'h0, 3'h1, 3'h2};
    logic        halt_exp [3] = '{1'b1, 1'b1, 1'b0};

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    serial_decimal_count_tally DUT (
        .clk(clk), .rst_b(rst_b), .adv_pulse(adv_pulse),
        .convert_done_store(convert_done_store), .store_reject(store_reject),
        .clock_trigger(clock_trigger), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .phase_one_clear(phase_one_clear),
        .phase_two_read(phase_two_read), .phase_three_write(phase_three_write),
        .phase_four_finish(phase_four_finish), .group_overflow(group_overflow),
        .auto_halt(auto_halt), .busy(busy)
    );

    converter_model conv (
        .clk(clk), .adv_pulse(adv_pulse), .convert_done_store(convert_done_store),
        .store_reject(store_reject), .clock_trigger(clock_trigger)
    );

    // Phase lines gathered, overflow pulses counted
    assign ph = {phase_four_finish, phase_three_write, phase_two_read, phase_one_clear};
    always @(posedge clk) begin
        if (group_overflow === 1'b1) begin
            ovf_seen <= ovf_seen + 1;
        end
    end

    task automatic give_verdict;
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic stop_on_hang(input string what);
        mismatches++;
        $display("unexpected hang in %s", what);
        give_verdict;
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= 4'hF;
        write <= wr;
        read <= ~wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (waitrequest !== 1'b0) stop_on_hang("bus");
    endtask

    task automatic mem_set(input logic [11:0] loc, input logic [3:0] v);
        bus(1'b1, OFS_MADDR, {20'h0, loc}, rd);
        bus(1'b1, OFS_MDATA, {28'h0, v}, rd);
    endtask

    task automatic mem_get(input logic [11:0] loc);
        bus(1'b1, OFS_MADDR, {20'h0, loc}, rd);
        bus(1'b0, OFS_MDATA, 32'h0, rd);
    endtask

    // Follows every phase of the given number of digit cycles
    task automatic phases(input int cycles);
        int c, i, n, k;
        int len [4];
        len = '{PHASE_CYC, PHASE_CYC, PHASE_CYC, LAST_CYC};
        for (c = 0; c < cycles; c++) begin
            for (i = 0; i < 4; i++) begin
                n = 0;
                while (ph[i] !== 1'b1 && n < 5000) begin
                    @(posedge clk);
                    n++;
                end
                if (n >= 5000) stop_on_hang("phase");
                if (i > 0 || c > 0) `CHK("phase gap", 0, n)
                `CHK("phase lines", (4'h1 << i), ph)
                k = 0;
                while (ph[i] === 1'b1 && k < 2000) begin
                    @(posedge clk);
                    k++;
                end
                `CHK("phase length", len[i], k)
            end
        end
        `CHK("phase after last", 4'h0, ph)
        `CHK("busy", 1'b0, busy)
    endtask

    task automatic store(input int adv, input logic rej, input logic trig, input int cycles);
        fork
            conv.run(adv, rej, trig);
            phases(cycles);
        join
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("busy", 1'b0, busy)
        `CHK("auto halt", 1'b0, auto_halt)
        bus(1'b0, OFS_CTRL, 32'h0, rd);
        `CHK("control", 32'h0, rd)
        bus(1'b0, OFS_STAT, 32'h0, rd);
        `CHK("holding", M_PRESET, rd[6:3])
        bus(1'b0, 4'h1, 32'h0, rd);
        `CHK("unmapped", 32'h0, rd)
        // Add, subtract, non-add and recovery on channel three
        mem_set(12'h018, 4'h5);
        store(3, 1'b0, 1'b0, 1);
        mem_get(12'h018);
        `CHK("digit", 4'h6, rd[3:0])
        bus(1'b0, OFS_STAT, 32'h0, rd);
        `CHK("holding", M_PRESET, rd[6:3])
        bus(1'b1, OFS_CTRL, 32'h1, rd);
        store(3, 1'b0, 1'b0, 1);
        mem_get(12'h018);
        `CHK("digit", 4'h5, rd[3:0])
        bus(1'b1, OFS_CTRL, 32'h0, rd);
        store(3, 1'b1, 1'b0, 1);
        mem_get(12'h018);
        `CHK("digit", 4'h5, rd[3:0])
        store(3, 1'b0, 1'b0, 1);
        mem_get(12'h018);
        `CHK("digit", 4'h6, rd[3:0])
        // Carry into the next digit
        mem_set(12'h028, 4'h9);
        mem_set(12'h029, 4'h3);
        store(5, 1'b0, 1'b0, 2);
        mem_get(12'h028);
        `CHK("digit", 4'h0, rd[3:0])
        mem_get(12'h029);
        `CHK("digit", 4'h4, rd[3:0])
        // Channel zero without and with the clock trigger
        mem_set(12'h000, 4'h4);
        store(0, 1'b0, 1'b0, 1);
        mem_get(12'h000);
        `CHK("digit", 4'h4, rd[3:0])
        mem_set(12'h004, 4'h0);
        for (t = 0; t < 3; t++) begin
            for (j = 0; j < 4; j++) mem_set(j[11:0], 4'h9);
            bus(1'b1, OFS_CTRL, {24'h0, halt_sel[t], 5'h0}, rd);
            store(0, 1'b0, 1'b1, 5);
            `CHK("auto halt", halt_exp[t], auto_halt)
            bus(1'b1, OFS_STAT, 32'h2, rd);
            @(posedge clk);
            `CHK("auto halt", 1'b0, auto_halt)
        end
        mem_get(12'h004);
        `CHK("digit", 4'h3, rd[3:0])
        mem_get(12'h000);
        `CHK("digit", 4'h0, rd[3:0])
        // Quadrant group overflow
        bus(1'b1, OFS_CTRL, 32'h4, rd);
        mem_set(12'h010, 4'h7);
        store(130, 1'b0, 1'b0, 1);
        `CHK("overflow pulses", 1, ovf_seen)
        bus(1'b0, OFS_STAT, 32'h0, rd);
        `CHK("non add", 1'b0, rd[2])
        mem_get(12'h010);
        `CHK("digit", 4'h7, rd[3:0])
        // Half memory, section one: channel three lands in the upper half
        bus(1'b1, OFS_CTRL, 32'h0A, rd);
        mem_set(12'h818, 4'h1);
        store(3, 1'b0, 1'b0, 1);
        mem_get(12'h818);
        `CHK("digit", 4'h2, rd[3:0])
        give_verdict;
    end
endmodule // test_serial_decimal_count_tally
